// file: ramp_limit_regs.vh
// Register offsets, field positions and reset values of the ramp bound bank.
`ifndef RAMP_LIMIT_REGS_VH
`define RAMP_LIMIT_REGS_VH
`define UPPER_TOP_IDX   7'h51
`define UPPER_MID_IDX   7'h52
`define UPPER_LOW_IDX   7'h53
`define LOWER_TOP_IDX   7'h54
`define LOWER_MID_IDX   7'h55
`define LOWER_LOW_IDX   7'h56
`define RSVD_A_IDX      7'h57
`define RSVD_B_IDX      7'h58
`define RSVD_C_IDX      7'h59
`define RAMP_CTRL_IDX   7'h5A
`define RAMP_STEP_IDX   7'h5B
`define RAMP_POS_HI_IDX 7'h5C
`define RAMP_POS_LO_IDX 7'h5D
`define REG_RESET       16'h0000
`define CTRL_RUN_BIT    0
`define CTRL_CLR_BIT    1
`define STAT_HIGH_BIT   2
`define STAT_LOW_BIT    3
`define BANK_WORDS      9
`endif

// file: bound_word_bank.v
// Small memory of 16-bit configuration words with registered read data.
`timescale 1ns/10ps
module bound_word_bank #(
  parameter WORDS = 9,
  parameter AW    = 4
) (
  input  wire          clk_i,   // System clock.
  input  wire          rst_n_i, // Asynchronous reset, active low.
  input  wire          we_i,    // Write strobe.
  input  wire [AW-1:0] addr_i,  // Word index.
  input  wire [15:0]   wdata_i, // Write data.
  output reg  [15:0]   rdata_o, // Registered read data.
  output wire [WORDS*16-1:0] words_o // All words, flat.
);
  reg [15:0] mem [0:WORDS-1];
  integer i;
  genvar g;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (i = 0; i < WORDS; i = i + 1)
        mem[i] <= 16'h0000;
      rdata_o <= 16'h0000;
    end
    else
    begin
      if (we_i && (addr_i < WORDS))
        mem[addr_i] <= wdata_i;
      rdata_o <= (addr_i < WORDS) ? mem[addr_i] : 16'h0000;
    end
  end

  generate
    for (g = 0; g < WORDS; g = g + 1)
    begin : flat
      assign words_o[g*16 +: 16] = mem[g];
    end
  endgenerate
endmodule // bound_word_bank

// file: ramp_frequency_limit_regs.v
// Ramp bound register bank with Wishbone slave and clamped ramp offset.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`include "ramp_limit_regs.vh"

module ramp_frequency_limit_regs (
  input  wire        clk_i,       // System clock, 125 MHz.
  input  wire        rst_n_i,     // Asynchronous reset, active low.
  input  wire        wb_cyc_i,    // Wishbone cycle.
  input  wire        wb_stb_i,    // Wishbone strobe.
  input  wire        wb_we_i,     // Wishbone write enable.
  input  wire [31:0] wb_adr_i,    // Wishbone byte address.
  input  wire [3:0]  wb_sel_i,    // Wishbone byte selects.
  input  wire [31:0] wb_dat_i,    // Wishbone write data.
  input  wire        soft_reset_i, // Soft reset from register zero.
  output reg  [31:0] wb_dat_o,    // Wishbone read data.
  output reg         wb_ack_o,    // Wishbone acknowledge.
  output reg  [32:0] ramp_pos_o,  // Clamped ramp offset, two's complement.
  output reg         at_high_o,   // Offset held at upper bound.
  output reg         at_low_o     // Offset held at lower bound.
);
  wire [6:0]   idx = wb_adr_i[8:2];
  wire         req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         in_bank = (idx >= `UPPER_TOP_IDX) && (idx <= `RSVD_C_IDX);
  wire [6:0]   bank_off = idx - `UPPER_TOP_IDX;
  wire [3:0]   bank_a = bank_off[3:0];
  wire [15:0]  bank_rd;
  wire [143:0] words;
  reg  [15:0]  cur16;
  wire [15:0]  lane = {wb_sel_i[1] ? wb_dat_i[15:8] : cur16[15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : cur16[7:0]};
  reg          run;
  reg  [15:0]  step;
  reg          rd_pend;
  reg          rd_bank;
  reg  [31:0]  rd_local;

  // Each bound is bit 0 of its top word above the full mid and low words.
  wire [32:0] upper = {words[0], words[31:16], words[47:32]};
  wire [32:0] lower = {words[48], words[79:64], words[95:80]};

  // A write with a byte lane deselected in wb_sel_i still needs the current value
  // for the unselected byte; the bank read port is registered, so mirror it.
  always @*
  begin
    cur16 = 16'h0000;
    if (in_bank)
      cur16 = words[bank_a*16 +: 16];
  end

  // Soft reset rewrites the bank through its write port one word per cycle.
  reg  [3:0] wipe;
  wire       wiping = (wipe != 4'h0);
  wire       bank_we = wiping | (req & wb_we_i & in_bank);
  wire [3:0] bank_addr = wiping ? (wipe - 4'h1) : bank_a;
  wire [15:0] bank_wd = wiping ? `REG_RESET : lane;

  bound_word_bank #(
    .WORDS (`BANK_WORDS),
    .AW    (4)
  ) u_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (bank_we),
    .addr_i  (bank_addr),
    .wdata_i (bank_wd),
    .rdata_o (bank_rd),
    .words_o (words)
  );

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wipe <= 4'h0;
    else if (soft_reset_i)
      wipe <= 4'h9;
    else if (wiping)
      wipe <= wipe - 4'h1;
  end

  // Ramp offset: adds the signed step each cycle while run is set, held at zero otherwise, and saturates at the bounds.
  wire [32:0] stepx = {{17{step[15]}}, step};
  wire [33:0] sum = {ramp_pos_o[32], ramp_pos_o} + {stepx[32], stepx};
  wire        ovf_hi = ($signed(sum) > $signed({upper[32], upper}));
  wire        ovf_lo = ($signed(sum) < $signed({lower[32], lower}));

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ramp_pos_o <= 33'h0_0000_0000;
      at_high_o  <= 1'b0;
      at_low_o   <= 1'b0;
    end
    else if (!run)
    begin
      ramp_pos_o <= 33'h0_0000_0000;
      at_high_o  <= 1'b0;
      at_low_o   <= 1'b0;
    end
    else if (ovf_hi)
    begin
      ramp_pos_o <= upper;
      at_high_o  <= 1'b1;
      at_low_o   <= 1'b0;
    end
    else if (ovf_lo)
    begin
      ramp_pos_o <= lower;
      at_high_o  <= 1'b0;
      at_low_o   <= 1'b1;
    end
    else
    begin
      ramp_pos_o <= sum[32:0];
      at_high_o  <= 1'b0;
      at_low_o   <= 1'b0;
    end
  end

  // Bus slave: ack two cycles after the request so bank data is registered.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      run      <= 1'b0;
      step     <= 16'h0000;
      rd_pend  <= 1'b0;
      rd_bank  <= 1'b0;
      rd_local <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= rd_pend;
      rd_pend  <= req & ~rd_pend;
      if (soft_reset_i)
      begin
        run  <= 1'b0;
        step <= 16'h0000;
      end
      else if (req & ~rd_pend & wb_we_i)
      begin
        if (idx == `RAMP_CTRL_IDX && wb_sel_i[0])
          run <= wb_dat_i[`CTRL_RUN_BIT];
        if (idx == `RAMP_STEP_IDX)
          step <= lane;
      end
      if (req & ~rd_pend)
      begin
        rd_bank <= in_bank;
        case (idx)
          `RAMP_CTRL_IDX:
            rd_local <= {28'h000_0000, at_low_o, at_high_o, 1'b0, run};
          `RAMP_STEP_IDX:   rd_local <= {16'h0000, step};
          `RAMP_POS_HI_IDX: rd_local <= {31'h0000_0000, ramp_pos_o[32]};
          `RAMP_POS_LO_IDX: rd_local <= ramp_pos_o[31:0];
          default:          rd_local <= 32'h0000_0000;
        endcase
      end
      if (rd_pend)
        wb_dat_o <= rd_bank ? {16'h0000, bank_rd} : rd_local;
    end
  end
endmodule // ramp_frequency_limit_regs

// file: ramp_limit_checker_properties.sv
// Port assertions for the ramp bound register bank.
`timescale 1ns/10ps
module ramp_limit_checker (
  input wire        clk_i,      // Clock.
  input wire        rst_n_i,    // Reset, active low.
  input wire        wb_cyc_i,   // Cycle.
  input wire        wb_stb_i,   // Strobe.
  input wire        wb_we_i,    // Write enable.
  input wire [31:0] wb_adr_i,   // Byte address.
  input wire [31:0] wb_dat_o,   // Read data.
  input wire        wb_ack_o,   // Acknowledge.
  input wire [32:0] ramp_pos_o, // Ramp offset.
  input wire        at_high_o,  // Held at upper bound.
  input wire        at_low_o    // Held at lower bound.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_two_cycles: assert property ($rose(wb_cyc_i && wb_stb_i) |->
    !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("late ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |->
    $past(wb_cyc_i && wb_stb_i, 2)) else $error("ack without request");
  a_bank_word_width: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[8:2] < 7'h5a |-> wb_dat_o[31:16] == 16'h0000)
    else $error("bank word wider than 16 bits");
  a_bound_exclusive: assert property (!(at_high_o && at_low_o))
    else $error("both bounds flagged");
  a_reset_clear: assert property ($rose(rst_n_i) |->
    ramp_pos_o == 33'h0_0000_0000 && !at_high_o && !at_low_o && !wb_ack_o)
    else $error("outputs not clear after reset");
endmodule // ramp_limit_checker
bind ramp_frequency_limit_regs ramp_limit_checker ramp_limit_checker_i (
  .clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .ramp_pos_o, .at_high_o, .at_low_o);

// file: tb.sv
// Self-checking bench for the ramp bound register bank.
`timescale 1ns/10ps
module tb;
  reg         clk_i = 0, rst_n_i = 0, cyc = 0, we = 0, srst = 0;
  reg  [31:0] adr = 0, wdat = 0, rd;
  wire [31:0] dat_o;
  wire        ack, hi, lo;
  wire [32:0] pos;
  integer     n_errors = 0, comparisons = 0, i;
  always #4 clk_i = ~clk_i;
  // Strobe follows cycle: a classic master raises both together.
  ramp_frequency_limit_regs ramp_frequency_limit_regs_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .soft_reset_i(srst),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ramp_pos_o(pos), .at_high_o(hi),
    .at_low_o(lo));
  task acc(input w, input [6:0] idx, input [15:0] d);
  begin
    @(posedge clk_i);
    cyc <= 1; we <= w; adr <= {23'h00_0000, idx, 2'h0}; wdat <= {16'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0; we <= 0;
  end
  endtask
  task chk(input string nm, input [35:0] e, input [35:0] s);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  // Top words keep unused bits zero, as software must.
  function [15:0] val(input integer k);
    val = (k == 0 || k == 3) ? 16'h0001 : 16'ha5c0 + k[15:0];
  endfunction
  task finish_test;
  begin
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1;
    for (i = 0; i < 9; i = i + 1)
    begin
      acc(0, 7'h51 + i, 0);
      chk("reset word", 0, {4'h0, rd});
      acc(1, 7'h51 + i, val(i));
    end
    for (i = 0; i < 9; i = i + 1)
    begin
      acc(0, 7'h51 + i, 0);
      chk("bank word", {20'h0_0000, val(i)}, {4'h0, rd});
    end
    acc(1, 7'h7f, 16'hffff);
    acc(0, 7'h7f, 0);
    chk("unmapped", 0, {4'h0, rd});
    $display("test registers done");
    acc(1, 7'h51, 0); acc(1, 7'h52, 0); acc(1, 7'h53, 16'h0010);
    acc(1, 7'h54, 1); acc(1, 7'h55, 16'hffff); acc(1, 7'h56, 16'hfff0);
    acc(1, 7'h5b, 16'h0005); acc(1, 7'h5a, 16'h0001);
    repeat (10) @(posedge clk_i);
    chk("upper hold", {3'h2, 33'h0_0000_0010}, {1'b0, hi, lo, pos});
    acc(1, 7'h5b, 16'hfffb);
    repeat (12) @(posedge clk_i);
    chk("lower hold", {3'h1, 33'h1_ffff_fff0}, {1'b0, hi, lo, pos});
    $display("test clamp done");
    @(posedge clk_i) srst <= 1;
    @(posedge clk_i) srst <= 0;
    repeat (10) @(posedge clk_i);
    for (i = 0; i < 9; i = i + 1)
    begin
      acc(0, 7'h51 + i, 0);
      chk("soft reset word", 0, {4'h0, rd});
    end
    $display("test soft reset done");
    finish_test;
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_errors = n_errors + 1;
    finish_test;
  end
endmodule // tb
